// ---- design/nand_host_ctrl.sv ----
/*
   Wishbone-controlled NAND host: software issues single bus cycles,
   the controller refuses illegal sequences, waits out busy by status
   polling, keeps a bad block table and a program page tracker.
   Assumes a classic Wishbone master and one NAND device on the pins.
*/
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl #(
   parameter int BLOCKS = nand_host_pkg::BLOCKS,
   parameter int WB_CYC = nand_host_pkg::WB_CYC
) (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic [3:0] ADR_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   input wire logic WE_I,
   input wire logic [3:0] SEL_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   output logic ACK_O,
   output logic NAND_CE_N_O,
   output logic NAND_CLE_O,
   output logic NAND_ALE_O,
   output logic NAND_WE_N_O,
   output logic READ_STROBE_N_O,
   output logic NAND_WP_N_O,
   output logic [7:0] NAND_IO_O,
   output logic NAND_IO_OE_O,
   input wire logic [7:0] NAND_IO_I,
   input wire logic READY_BUSY_LINE_I
);
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_CYC = 6'h02,
      S_WB = 6'h04,
      S_SCMD = 6'h08,
      S_SREAD = 6'h10,
      S_RESUME = 6'h20
   } state_t;

   function automatic logic is_defined(input logic [7:0] c);
      case (c)
         nand_host_pkg::CMD_READ, nand_host_pkg::CMD_RD_CHG, nand_host_pkg::CMD_PROG,
         nand_host_pkg::CMD_PROG_CACHE, nand_host_pkg::CMD_READ_GO, nand_host_pkg::CMD_CACHE_RD,
         nand_host_pkg::CMD_COPY_RD, nand_host_pkg::CMD_CACHE_END, nand_host_pkg::CMD_ERASE,
         nand_host_pkg::CMD_STATUS, nand_host_pkg::CMD_DATA_IN, nand_host_pkg::CMD_COL_CHG,
         nand_host_pkg::CMD_COPY_IN, nand_host_pkg::CMD_ID, nand_host_pkg::CMD_ERASE_GO,
         nand_host_pkg::CMD_WR_CHG, nand_host_pkg::CMD_RESET: is_defined = 1'b1;
         default: is_defined = 1'b0;
      endcase
   endfunction

   function automatic logic makes_busy(input logic [7:0] c);
      case (c)
         nand_host_pkg::CMD_PROG, nand_host_pkg::CMD_PROG_CACHE, nand_host_pkg::CMD_READ_GO,
         nand_host_pkg::CMD_CACHE_RD, nand_host_pkg::CMD_COPY_RD, nand_host_pkg::CMD_CACHE_END,
         nand_host_pkg::CMD_ERASE_GO, nand_host_pkg::CMD_RESET: makes_busy = 1'b1;
         default: makes_busy = 1'b0;
      endcase
   endfunction

   state_t state;
   logic ack;
   logic [7:0] op_byte;
   logic [1:0] op_kind;
   logic op_check;
   logic prog_pending;
   logic status_mode;
   logic init_done;
   logic [2:0] addr_idx;
   logic row_from_zero;
   logic [15:0] row;
   logic trk_valid;
   logic [9:0] trk_block;
   logic [5:0] trk_page;
   logic [2:0] trk_cnt;
   logic [BLOCKS-1:0] bad_tbl;
   logic refused;
   logic prog_fail;
   logic erase_fail;
   logic chunk_flag;
   logic [8:0] chunk_cnt;
   logic [7:0] rd_byte;
   logic [7:0] st_byte;
   logic [1:0] ctrl;
   logic [1:0] post;
   logic [3:0] wb_cnt;
   logic launched;
   logic eng_done;
   logic [7:0] eng_rdata;

   // Bus decode
   wire wb_req = CYC_I & STB_I;
   wire wb_wr = wb_req & ack & WE_I;
   wire wr_op = wb_wr & (ADR_I == nand_host_pkg::ADR_OP) & SEL_I[0] & SEL_I[1];
   wire wr_ctrl = wb_wr & (ADR_I == nand_host_pkg::ADR_CTRL) & SEL_I[0];
   wire wr_stat = wb_wr & (ADR_I == nand_host_pkg::ADR_STATUS);
   wire clr_refused = wr_stat & SEL_I[0] & DAT_I[nand_host_pkg::SF_REFUSED];
   wire clr_pfail = wr_stat & SEL_I[0] & DAT_I[nand_host_pkg::SF_PFAIL];
   wire clr_efail = wr_stat & SEL_I[0] & DAT_I[nand_host_pkg::SF_EFAIL];
   wire clr_chunk = wr_stat & SEL_I[3] & DAT_I[nand_host_pkg::SF_CHUNK];

   // Checks on the requested cycle
   wire [1:0] new_kind = DAT_I[nand_host_pkg::OPF_KIND +: 2];
   wire [7:0] new_byte = DAT_I[7:0];
   wire new_check = DAT_I[nand_host_pkg::OPF_CHECK];
   wire is_cmd = (new_kind == nand_host_pkg::KIND_CMD);
   wire cmd_reset = is_cmd & (new_byte == nand_host_pkg::CMD_RESET);
   wire cmd_status = is_cmd & (new_byte == nand_host_pkg::CMD_STATUS);
   wire cmd_data_in = is_cmd & (new_byte == nand_host_pkg::CMD_DATA_IN);
   wire cmd_col = is_cmd & (new_byte == nand_host_pkg::CMD_COL_CHG);
   wire cmd_confirm = is_cmd & ((new_byte == nand_host_pkg::CMD_PROG) |
                                (new_byte == nand_host_pkg::CMD_PROG_CACHE));
   wire cmd_erase_go = is_cmd & (new_byte == nand_host_pkg::CMD_ERASE_GO);
   wire cmd_read = is_cmd & (new_byte == nand_host_pkg::CMD_READ);
   wire [9:0] cur_block = row[15:6];
   wire [5:0] cur_page = row[5:0];
   wire same_block = trk_valid & (cur_block == trk_block);
   wire status_rd_ok = (new_kind == nand_host_pkg::KIND_RDATA) & status_mode;
   wire bad_code = is_cmd & !is_defined(new_byte); // R5
   wire init_block = !init_done & !cmd_reset & !cmd_status & !status_rd_ok; // R3
   wire after80_block = prog_pending & is_cmd & !cmd_col & !cmd_confirm & !cmd_reset; // R6
   wire order_block = cmd_confirm & same_block & ((cur_page < trk_page) | // R8
                      ((cur_page == trk_page) & (trk_cnt >= nand_host_pkg::PARTIAL_MAX))); // R13
   wire bad_hit = (cmd_confirm | cmd_erase_go) & bad_tbl[cur_block]; // R15 R16 R17
   wire refuse = (state != S_IDLE) | bad_code | init_block | after80_block | order_block | bad_hit; // R4
   wire accept = wr_op & !refuse;

   // Engine launch
   wire auto_state = (state == S_SCMD) | (state == S_SREAD) | (state == S_RESUME);
   wire eng_start = accept | (auto_state & !launched);
   wire [1:0] eng_kind = accept ? new_kind :
                         (state == S_SREAD) ? nand_host_pkg::KIND_RDATA : nand_host_pkg::KIND_CMD;
   wire [7:0] eng_byte = accept ? new_byte :
                         (state == S_SCMD) ? nand_host_pkg::CMD_STATUS : nand_host_pkg::CMD_READ;
   wire st_ready = eng_rdata[nand_host_pkg::ST_RDY]; // R20
   wire st_fail = eng_rdata[nand_host_pkg::ST_FAIL]; // R20
   wire data_rd_done = (state == S_CYC) & eng_done & (op_kind == nand_host_pkg::KIND_RDATA);
   wire data_byte_done = data_rd_done & !status_mode;
   wire mark_scan = data_byte_done & op_check & (eng_rdata == nand_host_pkg::BAD_MARK); // R14
   wire poll_done = (state == S_SREAD) & eng_done & st_ready;
   wire mark_fail = poll_done & st_fail & ((post == nand_host_pkg::POST_PROG) |
                                           (post == nand_host_pkg::POST_ERASE)); // R16 R17
   wire chunk_wrap = data_byte_done & (chunk_cnt == 9'(nand_host_pkg::ECC_CHUNK_BYTES - 1)); // R18

   wire [31:0] status_word = {7'h00, chunk_flag, st_byte, rd_byte, status_mode, bad_tbl[cur_block],
                              erase_fail, prog_fail, init_done, READY_BUSY_LINE_I, refused,
                              (state != S_IDLE)};
   wire [31:0] rd_mux = (ADR_I == nand_host_pkg::ADR_OP) ? {21'h000000, op_check, op_kind, op_byte} :
                        (ADR_I == nand_host_pkg::ADR_STATUS) ? status_word :
                        (ADR_I == nand_host_pkg::ADR_CTRL) ? {30'h00000000, ctrl} : 32'h00000000;

   assign ACK_O = ack;
   assign NAND_CE_N_O = !ctrl[0];
   assign NAND_WP_N_O = ctrl[1];

   nand_pin_cycle u_cycle (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .start_i(eng_start),
      .kind_i(eng_kind),
      .byte_i(eng_byte),
      .done_o(eng_done),
      .rdata_o(eng_rdata),
      .cle_o(NAND_CLE_O),
      .ale_o(NAND_ALE_O),
      .we_n_o(NAND_WE_N_O),
      .rd_n_o(READ_STROBE_N_O),
      .io_o(NAND_IO_O),
      .io_oe_o(NAND_IO_OE_O),
      .io_i(NAND_IO_I)
   );

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         ack <= 1'b0;
         DAT_O <= 32'h00000000;
      end else begin
         ack <= wb_req & !ack;
         if (wb_req & !ack) begin
            DAT_O <= rd_mux;
         end
      end
   end

   // Sticky flags: a set in the clearing cycle wins
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         refused <= 1'b0;
         prog_fail <= 1'b0;
         erase_fail <= 1'b0;
         chunk_flag <= 1'b0;
         ctrl <= nand_host_pkg::CTRL_RESET;
         init_done <= 1'b0;
      end else begin
         refused <= (wr_op & refuse) | (refused & !clr_refused);
         prog_fail <= (mark_fail & (post == nand_host_pkg::POST_PROG)) | (prog_fail & !clr_pfail);
         erase_fail <= (mark_fail & (post == nand_host_pkg::POST_ERASE)) | (erase_fail & !clr_efail);
         chunk_flag <= chunk_wrap | (chunk_flag & !clr_chunk);
         if (wr_ctrl) begin
            ctrl <= DAT_I[1:0];
         end
         if (READY_BUSY_LINE_I | poll_done) begin
            init_done <= 1'b1; // R3
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         bad_tbl <= '0;
         chunk_cnt <= 9'h000;
         rd_byte <= 8'h00;
         st_byte <= 8'h00;
      end else begin
         if (mark_scan | mark_fail) begin
            bad_tbl[cur_block] <= 1'b1; // R14 R16 R17
         end
         if (accept & is_cmd) begin
            chunk_cnt <= 9'h000;
         end else if (data_byte_done) begin
            chunk_cnt <= chunk_cnt + 9'h001; // R18
         end
         if (data_byte_done) begin
            rd_byte <= eng_rdata;
         end
         if ((data_rd_done & status_mode) | ((state == S_SREAD) & eng_done)) begin
            st_byte <= eng_rdata; // R19 R20
         end
      end
   end

   // Command sequence and address tracking
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         op_byte <= 8'h00;
         op_kind <= nand_host_pkg::KIND_CMD;
         op_check <= 1'b0;
         prog_pending <= 1'b0;
         status_mode <= 1'b0;
         addr_idx <= 3'h0;
         row_from_zero <= 1'b0;
         row <= 16'h0000;
      end else if (accept) begin
         op_byte <= new_byte;
         op_kind <= new_kind;
         op_check <= new_check;
         if (is_cmd) begin
            addr_idx <= 3'h0;
            row_from_zero <= (new_byte == nand_host_pkg::CMD_ERASE);
            if (cmd_data_in) begin
               prog_pending <= 1'b1; // R6
            end else if (!cmd_col) begin
               prog_pending <= 1'b0; // R7
            end
            if (cmd_status) begin
               status_mode <= 1'b1; // R9
            end else if (cmd_read | cmd_reset) begin
               status_mode <= 1'b0; // R10 R21
            end
         end else if (new_kind == nand_host_pkg::KIND_ADDR) begin
            if (addr_idx != 3'h7) begin
               addr_idx <= addr_idx + 3'h1;
            end
            // Row bytes follow two column bytes, or come first after 60h; later bytes change nothing
            if (addr_idx == (row_from_zero ? 3'h0 : 3'h2)) begin
               row[7:0] <= new_byte;
            end else if (addr_idx == (row_from_zero ? 3'h1 : 3'h3)) begin
               row[15:8] <= new_byte; // R12
            end
         end
      end else if ((state == S_SREAD) & eng_done) begin
         status_mode <= 1'b1; // R19
      end else if ((state == S_RESUME) & eng_done) begin
         status_mode <= 1'b0; // R10
      end
   end

   // Program order tracker for the last programmed block
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         trk_valid <= 1'b0;
         trk_block <= 10'h000;
         trk_page <= 6'h00;
         trk_cnt <= 3'h0;
      end else if (accept & cmd_confirm) begin
         trk_valid <= 1'b1;
         trk_block <= cur_block;
         trk_page <= cur_page;
         if (same_block & (cur_page == trk_page)) begin
            trk_cnt <= trk_cnt + 3'h1; // R13
         end else begin
            trk_cnt <= 3'h1; // R8
         end
      end else if (accept & cmd_erase_go & same_block) begin
         trk_valid <= 1'b0;
      end
   end

   // Busy handling: every busy period after a command is ended by polling status, so a
   // busy line shared with other devices never misleads the controller
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         state <= S_IDLE;
         launched <= 1'b0;
         post <= nand_host_pkg::POST_NONE;
         wb_cnt <= 4'h0;
      end else begin
         if (eng_start) begin
            launched <= 1'b1;
         end else if (eng_done) begin
            launched <= 1'b0;
         end
         case (state)
            S_IDLE: begin
               if (accept) begin
                  state <= S_CYC;
               end
            end
            S_CYC: begin
               if (eng_done) begin
                  if ((op_kind == nand_host_pkg::KIND_CMD) & makes_busy(op_byte)) begin
                     wb_cnt <= 4'h0;
                     state <= S_WB; // R4
                     case (op_byte)
                        nand_host_pkg::CMD_PROG, nand_host_pkg::CMD_PROG_CACHE:
                           post <= nand_host_pkg::POST_PROG;
                        nand_host_pkg::CMD_ERASE_GO: post <= nand_host_pkg::POST_ERASE;
                        nand_host_pkg::CMD_READ_GO: post <= nand_host_pkg::POST_READ;
                        default: post <= nand_host_pkg::POST_NONE;
                     endcase
                  end else begin
                     state <= S_IDLE;
                  end
               end
            end
            S_WB: begin
               wb_cnt <= wb_cnt + 4'h1;
               if (wb_cnt == 4'(WB_CYC - 1)) begin
                  state <= S_SCMD;
               end
            end
            S_SCMD: begin
               if (eng_done) begin
                  state <= S_SREAD; // R19
               end
            end
            S_SREAD: begin
               if (poll_done) begin
                  state <= (post == nand_host_pkg::POST_READ) ? S_RESUME : S_IDLE; // R10
               end
            end
            S_RESUME: begin
               if (eng_done) begin
                  state <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- design/nand_host_pkg.sv ----
/*
   Constants shared by the NAND host controller and its pin cycle engine.
   Assumes a 50 MHz system clock and a byte-wide NAND command/address/data port.
*/
// Behaviour
// [R1] Device aborts any operation on FFh reset
// [R2] Reset in cached program may abort previous page
// [R3] During power-up busy only FFh or 70h allowed
// [R4] Host issues only 70h or FFh while busy
// [R5] Host issues only defined command codes
// [R6] After 80h only 85h, 10h, 15h, FFh follow
// [R7] Other command after 80h skips the program
// [R8] Pages programmed in ascending order per block
// [R9] 70h in read mode selects status output
// [R10] 00h after status resumes data without address
// [R11] Write-protect low aborts program and erase
// [R12] Fifth address cycle is ignored
// [R13] At most 4 partial programs per page
// [R14] Block with 00h marker byte is bad
// [R15] Never erase a block marked bad
// [R16] Program failure: rewrite elsewhere, exclude block
// [R17] Erase failure: record block bad, block access
// [R18] Host corrects 8 bits per 512 bytes
// [R19] Shared busy line: learn state by status read
// [R20] Status bits: 0 fail, 5 ready, 7 unprotected
// [R21] Status ready after reset; repeated resets accepted
package nand_host_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int T_STROBE_NS = 25;
   localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_WB_NS = 100;
   localparam int WB_CYC = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLOCKS = 1024;
   localparam int ECC_CHUNK_BYTES = 512;
   localparam logic [2:0] PARTIAL_MAX = 3'h4;
   localparam logic [7:0] BAD_MARK = 8'h00;

   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_RD_CHG = 8'h05;
   localparam logic [7:0] CMD_PROG = 8'h10;
   localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
   localparam logic [7:0] CMD_READ_GO = 8'h30;
   localparam logic [7:0] CMD_CACHE_RD = 8'h31;
   localparam logic [7:0] CMD_COPY_RD = 8'h35;
   localparam logic [7:0] CMD_CACHE_END = 8'h3f;
   localparam logic [7:0] CMD_ERASE = 8'h60;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_DATA_IN = 8'h80;
   localparam logic [7:0] CMD_COL_CHG = 8'h85;
   localparam logic [7:0] CMD_COPY_IN = 8'h8c;
   localparam logic [7:0] CMD_ID = 8'h90;
   localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
   localparam logic [7:0] CMD_WR_CHG = 8'he0;
   localparam logic [7:0] CMD_RESET = 8'hff;

   localparam logic [1:0] KIND_CMD = 2'h0;
   localparam logic [1:0] KIND_ADDR = 2'h1;
   localparam logic [1:0] KIND_WDATA = 2'h2;
   localparam logic [1:0] KIND_RDATA = 2'h3;

   localparam logic [1:0] POST_NONE = 2'h0;
   localparam logic [1:0] POST_PROG = 2'h1;
   localparam logic [1:0] POST_ERASE = 2'h2;
   localparam logic [1:0] POST_READ = 2'h3;

   localparam int ST_FAIL = 0;
   localparam int ST_RDY = 5;
   localparam int ST_WP = 7;

   localparam logic [3:0] ADR_OP = 4'h0;
   localparam logic [3:0] ADR_STATUS = 4'h4;
   localparam logic [3:0] ADR_CTRL = 4'h8;
   localparam logic [1:0] CTRL_RESET = 2'h1;

   localparam int OPF_KIND = 8;
   localparam int OPF_CHECK = 10;
   localparam int SF_REFUSED = 1;
   localparam int SF_PFAIL = 4;
   localparam int SF_EFAIL = 5;
   localparam int SF_CHUNK = 24;
endpackage

// ---- design/nand_pin_cycle.sv ----
/*
   One NAND bus cycle: command, address, data write or data read.
   Assumes the caller starts a cycle only while the engine is idle.
*/
`timescale 1ns/1ps
`default_nettype none
module nand_pin_cycle #(
   parameter int STROBE_CYC = nand_host_pkg::STROBE_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [1:0] kind_i,
   input wire logic [7:0] byte_i,
   output logic done_o,
   output logic [7:0] rdata_o,
   output logic cle_o,
   output logic ale_o,
   output logic we_n_o,
   output logic rd_n_o,
   output logic [7:0] io_o,
   output logic io_oe_o,
   input wire logic [7:0] io_i
);
   typedef enum logic [3:0] {
      P_IDLE = 4'h1,
      P_SETUP = 4'h2,
      P_LOW = 4'h4,
      P_HIGH = 4'h8
   } phase_t;

   phase_t phase;
   logic [3:0] cnt;
   logic rd_cycle;
   wire cnt_end = (cnt == 4'(STROBE_CYC - 1));

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         phase <= P_IDLE;
         cnt <= 4'h0;
         rd_cycle <= 1'b0;
         done_o <= 1'b0;
         rdata_o <= 8'h00;
         cle_o <= 1'b0;
         ale_o <= 1'b0;
         we_n_o <= 1'b1;
         rd_n_o <= 1'b1;
         io_o <= 8'h00;
         io_oe_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         case (phase)
            P_IDLE: begin
               if (start_i) begin
                  // Latches and data settle one cycle before the strobe falls
                  rd_cycle <= (kind_i == nand_host_pkg::KIND_RDATA);
                  cle_o <= (kind_i == nand_host_pkg::KIND_CMD);
                  ale_o <= (kind_i == nand_host_pkg::KIND_ADDR);
                  io_o <= byte_i;
                  io_oe_o <= (kind_i != nand_host_pkg::KIND_RDATA);
                  phase <= P_SETUP;
               end
            end
            P_SETUP: begin
               we_n_o <= rd_cycle;
               rd_n_o <= !rd_cycle;
               cnt <= 4'h0;
               phase <= P_LOW;
            end
            P_LOW: begin
               cnt <= cnt + 4'h1;
               if (cnt_end) begin
                  if (rd_cycle) begin
                     rdata_o <= io_i;
                  end
                  we_n_o <= 1'b1;
                  rd_n_o <= 1'b1;
                  cnt <= 4'h0;
                  phase <= P_HIGH;
               end
            end
            P_HIGH: begin
               cnt <= cnt + 4'h1;
               if (cnt_end) begin
                  cle_o <= 1'b0;
                  ale_o <= 1'b0;
                  io_oe_o <= 1'b0;
                  done_o <= 1'b1;
                  phase <= P_IDLE;
               end
            end
            default: phase <= P_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- tb/nand_dev_model.sv ----
/* NAND device model: busy, status, data.
   Assumes host strobes on the bench clock. */
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model (
   input wire logic clk_i,
   input wire logic ce_n_i,
   input wire logic cle_i,
   input wire logic we_n_i,
   input wire logic rd_n_i,
   input wire logic wp_n_i,
   input wire logic [7:0] io_i,
   input wire logic fail_i,
   input wire logic [7:0] data_i,
   output logic [7:0] io_o,
   output logic rb_o
);
   int busy = 40;
   logic we_q = 1'b1;
   logic stat = 1'b0;
   logic pend = 1'b0;
   logic fail = 1'b0;
   logic [7:0] cur;
   // Address bytes are not latched
   wire take = !ce_n_i && cle_i && we_n_i && !we_q && (rb_o || io_i inside {8'h70, 8'hff});
   assign rb_o = busy == 0;
   assign cur = stat ? {wp_n_i, rb_o, rb_o, 4'h0, fail} : data_i;
   assign io_o = rd_n_i ? ~cur : cur;
   always @(posedge clk_i) begin
      we_q <= we_n_i;
      if (busy > 0) busy <= busy - 1;
      if (take) begin
         stat <= io_i == 8'h70 || (stat && io_i != 8'h00);
         pend <= io_i == 8'h80 || (pend && io_i == 8'h85);
         if (io_i == 8'hff) begin
            busy <= 10;
            fail <= 1'b0;
         end
         if ((pend && io_i inside {8'h10, 8'h15}) || io_i == 8'hd0) begin
            busy <= 30;
            fail <= fail_i || !wp_n_i;
         end
         if (io_i == 8'h30) busy <= 10;
      end
   end
endmodule
`default_nettype wire

// ---- tb/nand_host_ctrl_properties.sv ----
/* NAND host port assertions.
   Assumes a bind and one clock. */
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl_properties (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic [3:0] ADR_I,
   input wire logic WE_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic ACK_O,
   input wire logic [31:0] DAT_O,
   input wire logic NAND_CLE_O,
   input wire logic NAND_WE_N_O,
   input wire logic READ_STROBE_N_O,
   input wire logic [7:0] NAND_IO_O,
   input wire logic NAND_IO_OE_O,
   input wire logic READY_BUSY_LINE_I
);
   logic we_q;
   logic in_ser;
   wire cmd_rise = NAND_CLE_O && NAND_WE_N_O && !we_q;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   // Set from 80h to its closing command
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         we_q <= 1'b1;
         in_ser <= 1'b0;
      end else begin
         we_q <= NAND_WE_N_O;
         if (cmd_rise) begin
            in_ser <= NAND_IO_O == 8'h80 || (in_ser && NAND_IO_O == 8'h85);
         end
      end
   end
   ack_pulse_a: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
   ack_answer_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("no ack");
   ack_cause_a: assert property (!(CYC_I && STB_I) |=> !ACK_O) else $error("stray ack");
   unmapped_zero_a: assert property (CYC_I && STB_I && !ACK_O && !WE_I && ADR_I == 4'hc |=> DAT_O == 32'h0)
      else $error("unmapped read");
   read_release_a: assert property (!READ_STROBE_N_O |-> !NAND_IO_OE_O && NAND_WE_N_O)
      else $error("io driven in read");
   strobe_hold_a: assert property (!NAND_WE_N_O |-> NAND_IO_OE_O && $stable(NAND_IO_O))
      else $error("io moved in write");
   we_width_a: assert property ($fell(NAND_WE_N_O) |=> !NAND_WE_N_O ##1 NAND_WE_N_O) else $error("strobe width");
   busy_cmd_a: assert property (cmd_rise && !READY_BUSY_LINE_I |-> NAND_IO_O inside {8'h70, 8'hff})
      else $error("cmd while busy");
   cmd_defined_a: assert property (cmd_rise |-> NAND_IO_O inside {8'h00, 8'h05, 8'h10, 8'h15, 8'h30, 8'h31,
      8'h35, 8'h3f, 8'h60, 8'h70, 8'h80, 8'h85, 8'h8c, 8'h90, 8'hd0, 8'he0, 8'hff}) else $error("undefined cmd");
   ser_follow_a: assert property (cmd_rise && in_ser |-> NAND_IO_O inside {8'h85, 8'h10, 8'h15, 8'hff})
      else $error("bad cmd after 80h");
   cover property (cmd_rise && NAND_IO_O == 8'h10);
   cover property (cmd_rise && NAND_IO_O == 8'hd0);
   cover property ($fell(READ_STROBE_N_O));
endmodule
`default_nettype wire

// ---- tb/test_nand_host_ctrl.sv ----
/* Self-checking bench for the NAND host controller.
   Assumes a model busy after power-up. */
`timescale 1ns/1ps
`default_nettype none
module test_nand_host_ctrl;
   logic CLK_I = 0, RST_N_I = 0, WE_I = 0, CYC_I = 0, STB_I = 0, chk = 0, fail = 0;
   logic [3:0] ADR_I = '0, SEL_I = '0;
   logic [31:0] DAT_I = '0, DAT_O, q, lfsr = 32'ha149, ev[$], em[$];
   logic [7:0] NAND_IO_O, NAND_IO_I, dbyte = '0;
   logic ACK_O, NAND_CE_N_O, NAND_CLE_O, NAND_ALE_O, NAND_WE_N_O, READ_STROBE_N_O, NAND_WP_N_O;
   logic NAND_IO_OE_O, READY_BUSY_LINE_I;
   logic [7:0] undef[3] = '{8'h11, 8'ha5, 8'hfe};
   int num_errors = 0, n_tests = 0, cycles = 0;
   always #10 CLK_I = ~CLK_I;
   nand_host_ctrl uut (.*);
   nand_dev_model dev (.clk_i(CLK_I), .ce_n_i(NAND_CE_N_O), .cle_i(NAND_CLE_O), .we_n_i(NAND_WE_N_O),
      .rd_n_i(READ_STROBE_N_O), .wp_n_i(NAND_WP_N_O), .io_i(NAND_IO_O), .fail_i(fail), .data_i(dbyte),
      .io_o(NAND_IO_I), .rb_o(READY_BUSY_LINE_I));
   function logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task wb(input logic [3:0] a, logic w, logic [31:0] d, logic c);
      @(posedge CLK_I);
      {ADR_I, WE_I, DAT_I, SEL_I, CYC_I, STB_I, chk} <= {a, w, d, 4'hf, 2'b11, c};
      do @(posedge CLK_I); while (ACK_O !== 1'b1);
      q = DAT_O;
      {CYC_I, STB_I, chk} <= 3'b0;
   endtask
   task expect_reg(input logic [31:0] m, v, logic [3:0] a = 4'h4);
      em.push_back(m);
      ev.push_back(v);
      wb(a, 1'b0, 32'h0, 1'b1);
   endtask
   task op(input logic [10:0] x);
      wb(4'h0, 1'b1, {21'h0, x}, 1'b0);
      do wb(4'h4, 1'b0, 32'h0, 1'b0); while (q[0] !== 1'b0);
   endtask
   task row_adr(input logic [15:0] r);
      for (int i = 0; i < 4; i++) op({3'h1, 8'({r, 16'h0} >> (8 * i))});
   endtask
   task prog(input logic [15:0] r, logic [7:0] fin);
      op(11'h080);
      row_adr(r);
      lfsr = step(lfsr);
      op({3'h2, lfsr[7:0]});
      op({3'h0, fin});
   endtask
   task refused(input logic e);
      expect_reg(32'h2, {30'h0, e, 1'b0});
      wb(4'h4, 1'b1, 32'h2, 1'b0);
   endtask
   task cmp_reg(input logic [31:0] seen);
      n_tests++;
      if ((seen & em[0]) !== ev[0]) begin
         num_errors++;
         $display("BAD status word expected %h seen %h", ev[0], seen & em[0]);
      end
      em.delete(0);
      ev.delete(0);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge CLK_I) begin
      cycles++;
      if (chk && ACK_O === 1'b1) cmp_reg(DAT_O);
      if (cycles > 60000) begin
         num_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (2) @(posedge CLK_I);
      RST_N_I <= 1'b1;
      expect_reg(32'h3, 32'h1, 4'h8);
      expect_reg('1, 32'h0, 4'hc);
      op(11'h000);
      refused(1'b1);
      repeat (2) op(11'h0ff);
      expect_reg(32'hff0009, 32'h600008);
      $display("end of power-up");
      wb(4'h8, 1'b1, 32'h3, 1'b0);
      foreach (undef[i]) begin
         op(11'(undef[i]));
         refused(1'b1);
      end
      prog(16'h0002, 8'h30);
      refused(1'b1);
      op(11'h010);
      expect_reg(32'hff0012, 32'he00000);
      for (int i = 0; i < 4; i++) begin
         prog(16'h0002, 8'h10);
         refused(i == 3);
      end
      op(11'h0ff);
      prog(16'h0001, 8'h10);
      refused(1'b1);
      op(11'h0ff);
      $display("end of programming");
      fail <= 1'b1;
      prog(16'h0003, 8'h10);
      fail <= 1'b0;
      expect_reg(32'hff0050, 32'he10050);
      prog(16'h0004, 8'h10);
      refused(1'b1);
      op(11'h0ff);
      $display("end of program failure");
      lfsr = step(lfsr);
      dbyte <= lfsr[7:0];
      op(11'h000);
      row_adr(16'h0080);
      op(11'h030);
      op(11'h300);
      expect_reg(32'hff80, {16'h0, dbyte, 8'h00});
      op(11'h070);
      expect_reg(32'h80, 32'h80);
      op(11'h000);
      op(11'h300);
      expect_reg(32'hff80, {16'h0, dbyte, 8'h00});
      repeat (511) op(11'h300);
      expect_reg(32'h1000000, 32'h1000000);
      $display("end of read mode");
      dbyte <= 8'h00;
      op(11'h000);
      row_adr(16'h0040);
      op(11'h030);
      op(11'h700);
      expect_reg(32'hff40, 32'h0040);
      op(11'h060);
      op(11'h140);
      op(11'h100);
      op(11'h0d0);
      refused(1'b1);
      op(11'h0ff);
      fail <= 1'b1;
      op(11'h060);
      op(11'h1c0);
      op(11'h100);
      op(11'h0d0);
      fail <= 1'b0;
      expect_reg(32'h60, 32'h60);
      $display("end of bad blocks");
      repeat (2) @(posedge CLK_I);
      give_verdict();
   end
endmodule
bind nand_host_ctrl nand_host_ctrl_properties chk_u (.*);
`default_nettype wire
